/* trig_io_timing.sv */
`timescale 1ns/1ps
// Summary of operation
// - per line, wait delay 0..1000 us in 10 us steps after exposure end; default 0.
// - hold exposure-end pulse for width 40..10000 us in 10 us steps; default 5000.
// - selectable pulse polarity, positive default; negative drives ON to OFF.
// - delay, width and polarity kept independently per line.
// - trigger seen ON only after staying ON for the filter width.
// - trigger seen OFF only after staying OFF for the filter width.
// - filter width 100,200,300,400 or 500 us; default 100.
// - multi-line random trigger mode uses line 0 filter width on all lines.
// - eight strobe outputs follow physical connector positions, not camera numbers.
// - strobe without camera selectable per line, using connector pulse width.
// - shared outputs carry strobe or exposure-end pulses by one setting; strobe default.
// - exposure-end outputs indexed by line number 0 to 7.
module trig_io_timing
  import trig_io_pkg::*;
(
  // clock and reset
  input  wire logic                 sys_clk_i,
  input  wire logic                 rst_b_i,
  // register port
  input  wire logic [5:0]           reg_addr_i,
  input  wire logic [31:0]          reg_wdata_i,
  input  wire logic                 reg_wr_i,
  input  wire logic                 reg_rd_i,
  output logic [31:0]               reg_rdata_o,
  // per-line events, same clock domain
  input  wire logic [NUM_LINES-1:0] exposure_done_i,
  input  wire logic [NUM_LINES-1:0] strobe_req_i,
  input  wire logic [NUM_LINES-1:0] camera_present_i,
  // trigger pins
  input  wire logic [NUM_LINES-1:0] trigger_pin_i,
  output logic [NUM_LINES-1:0]      trigger_o,
  // shared output lines
  output logic [NUM_LINES-1:0]      strobe_trigger_out_o
);

  typedef struct packed {
    line_cfg_t [NUM_LINES-1:0]    cfg;
    logic [NUM_LINES-1:0][2:0]    filt;
    logic [NUM_LINES-1:0]         no_cam_en;
    logic                         sel_exposure;
    logic                         multi_line;
    logic [10:0]                  tick_cnt;
    logic                         tick;
    pulse_state_t [NUM_LINES-1:0] pst;
    logic [NUM_LINES-1:0][9:0]    pcnt;
    pulse_state_t [NUM_LINES-1:0] sst;
    logic [NUM_LINES-1:0][9:0]    scnt;
    logic [NUM_LINES-1:0]         sync1;
    logic [NUM_LINES-1:0]         sync2;
    logic [NUM_LINES-1:0]         out;
    logic [NUM_LINES-1:0]         trig;
    logic [31:0]                  rdata;
  } top_st_t;

  top_st_t              st_q, st_d;
  reg_req_t             req;
  logic [NUM_LINES-1:0] filt_level;
  logic [NUM_LINES-1:0] exp_level;
  logic [NUM_LINES-1:0] stb_level;

  function automatic logic [9:0] clamp_width(input logic [9:0] w);
    if (w < WIDTH_MIN) begin
      clamp_width = WIDTH_MIN;
    end else if (w > WIDTH_MAX) begin
      clamp_width = WIDTH_MAX;
    end else begin
      clamp_width = w;
    end
  endfunction : clamp_width

  function automatic logic [2:0] clamp_filt(input logic [2:0] f);
    clamp_filt = (f > FILT_MAX) ? FILT_MAX : f;
  endfunction : clamp_filt

  assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

  genvar g;
  generate
    for (g = 0; g < NUM_LINES; g++) begin : g_filt
      trig_filter u_filt (
        .sys_clk_i  (sys_clk_i),
        .rst_b_i    (rst_b_i),
        .raw_i      (st_q.sync2[g]),
        .filt_sel_i (st_q.multi_line ? st_q.filt[0] : st_q.filt[g]),
        .level_o    (filt_level[g])
      );
    end
  endgenerate

  always_comb begin
    st_d       = st_q;
    st_d.sync1 = trigger_pin_i;
    st_d.sync2 = st_q.sync1;
    st_d.trig  = filt_level;

    // 10 us time base
    st_d.tick = 1'b0;
    if (st_q.tick_cnt == 11'(TICK_CYCLES - 1)) begin
      st_d.tick_cnt = '0;
      st_d.tick     = 1'b1;
    end else begin
      st_d.tick_cnt = st_q.tick_cnt + 11'h1;
    end

    // register writes
    if (req.wr) begin
      if (req.addr == ADDR_COMMON) begin
        st_d.sel_exposure = req.wdata[0];
        st_d.multi_line   = req.wdata[1];
        st_d.no_cam_en    = req.wdata[15:8];
      end else if (req.addr[5:3] == ADDR_LINE_BASE[5:3]) begin
        st_d.cfg[req.addr[2:0]].delay   = (req.wdata[6:0] > DELAY_MAX) ? DELAY_MAX : req.wdata[6:0];
        st_d.cfg[req.addr[2:0]].width   = clamp_width(req.wdata[17:8]);
        st_d.cfg[req.addr[2:0]].neg_pol = req.wdata[24];
      end else if (req.addr[5:3] == ADDR_FILT_BASE[5:3]) begin
        st_d.filt[req.addr[2:0]] = clamp_filt(req.wdata[2:0]);
      end
    end

    // register reads
    st_d.rdata = '0;
    if (req.rd) begin
      if (req.addr == ADDR_COMMON) begin
        st_d.rdata = {16'h0, st_q.no_cam_en, 6'h0, st_q.multi_line, st_q.sel_exposure};
      end else if (req.addr == ADDR_STATUS) begin
        st_d.rdata = {8'h0, st_q.trig, exp_level, stb_level};
      end else if (req.addr[5:3] == ADDR_LINE_BASE[5:3]) begin
        st_d.rdata = {7'h0, st_q.cfg[req.addr[2:0]].neg_pol, 6'h0, st_q.cfg[req.addr[2:0]].width,
                      1'b0, st_q.cfg[req.addr[2:0]].delay};
      end else if (req.addr[5:3] == ADDR_FILT_BASE[5:3]) begin
        st_d.rdata = {29'h0, st_q.filt[req.addr[2:0]]};
      end
    end

    for (int i = 0; i < NUM_LINES; i++) begin
      // exposure-end pulse per line number
      case (st_q.pst[i])
        PULSE_IDLE: begin
          if (exposure_done_i[i]) begin
            st_d.pcnt[i] = {3'h0, st_q.cfg[i].delay};
            st_d.pst[i]  = (st_q.cfg[i].delay == '0) ? PULSE_HIGH : PULSE_DELAY;
            if (st_q.cfg[i].delay == '0) begin
              st_d.pcnt[i] = st_q.cfg[i].width;
            end
          end
        end
        PULSE_DELAY: begin
          if (st_q.tick) begin
            if (st_q.pcnt[i] <= 10'h1) begin
              st_d.pst[i]  = PULSE_HIGH;
              st_d.pcnt[i] = st_q.cfg[i].width;
            end else begin
              st_d.pcnt[i] = st_q.pcnt[i] - 10'h1;
            end
          end
        end
        PULSE_HIGH: begin
          if (st_q.tick) begin
            if (st_q.pcnt[i] <= 10'h1) begin
              st_d.pst[i] = PULSE_IDLE;
            end else begin
              st_d.pcnt[i] = st_q.pcnt[i] - 10'h1;
            end
          end
        end
        default: st_d.pst[i] = PULSE_IDLE;
      endcase

      // strobe per connector position
      case (st_q.sst[i])
        PULSE_IDLE: begin
          if (strobe_req_i[i] && (camera_present_i[i] || st_q.no_cam_en[i])) begin
            st_d.sst[i]  = PULSE_HIGH;
            st_d.scnt[i] = st_q.cfg[i].width;
          end
        end
        PULSE_HIGH: begin
          if (st_q.tick) begin
            if (st_q.scnt[i] <= 10'h1) begin
              st_d.sst[i] = PULSE_IDLE;
            end else begin
              st_d.scnt[i] = st_q.scnt[i] - 10'h1;
            end
          end
        end
        default: st_d.sst[i] = PULSE_IDLE;
      endcase
    end

    // shared output select
    for (int i = 0; i < NUM_LINES; i++) begin
      st_d.out[i] = st_q.sel_exposure ? (exp_level[i] ^ st_q.cfg[i].neg_pol) : stb_level[i];
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_LINES; i++) begin
      exp_level[i] = (st_q.pst[i] == PULSE_HIGH);
      stb_level[i] = (st_q.sst[i] == PULSE_HIGH);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      st_q <= '0;
      for (int i = 0; i < NUM_LINES; i++) begin
        st_q.cfg[i].delay   <= DELAY_RESET;
        st_q.cfg[i].width   <= WIDTH_RESET;
        st_q.cfg[i].neg_pol <= POL_RESET;
        st_q.filt[i]        <= FILT_RESET;
      end
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata_o          = st_q.rdata;
  assign trigger_o            = st_q.trig;
  assign strobe_trigger_out_o = st_q.out;

endmodule : trig_io_timing

/* trig_io_pkg.sv */
package trig_io_pkg;

  localparam int unsigned CLK_MHZ        = 125;
  localparam int unsigned TICK_US        = 10;
  localparam int unsigned TICK_CYCLES    = CLK_MHZ * TICK_US;
  localparam int unsigned US_CYCLES      = CLK_MHZ;
  localparam int          NUM_LINES      = 8;

  // exposure-end timing, in 10 us ticks
  localparam logic [6:0]  DELAY_MAX      = 7'h64;
  localparam logic [6:0]  DELAY_RESET    = 7'h00;
  localparam logic [9:0]  WIDTH_MIN      = 10'h004;
  localparam logic [9:0]  WIDTH_MAX      = 10'h3e8;
  localparam logic [9:0]  WIDTH_RESET    = 10'h1f4;
  localparam logic        POL_RESET      = 1'b0;

  // trigger filter: code 0..4 means 100..500 us
  localparam logic [2:0]  FILT_RESET     = 3'h0;
  localparam logic [2:0]  FILT_MAX       = 3'h4;
  localparam logic [15:0] FILT_STEP_CYC  = 16'(100 * US_CYCLES);

  // register index (word address)
  localparam logic [5:0]  ADDR_COMMON    = 6'h00;
  localparam logic [5:0]  ADDR_STATUS    = 6'h01;
  localparam logic [5:0]  ADDR_LINE_BASE = 6'h10;
  localparam logic [5:0]  ADDR_FILT_BASE = 6'h20;

  typedef struct packed {
    logic [6:0] delay;
    logic [9:0] width;
    logic       neg_pol;
  } line_cfg_t;

  typedef enum logic [1:0] {
    PULSE_IDLE  = 2'b00,
    PULSE_DELAY = 2'b01,
    PULSE_HIGH  = 2'b11
  } pulse_state_t;

  typedef struct packed {
    logic [5:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

endpackage : trig_io_pkg

/* trig_filter.sv */
`timescale 1ns/1ps
module trig_filter
  import trig_io_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_b_i,
  // sampled input and width
  input  wire logic        raw_i,
  input  wire logic [2:0]  filt_sel_i,
  // filtered level
  output logic             level_o
);

  typedef struct packed {
    logic [18:0] cnt;
    logic        level;
  } filt_st_t;

  filt_st_t st_q, st_d;
  logic [18:0] limit;

  always_comb begin
    limit = 19'({16'h0, filt_sel_i} + 19'h1) * 19'(FILT_STEP_CYC);
    st_d  = st_q;
    if (raw_i == st_q.level) begin
      st_d.cnt = '0;
    end else if (st_q.cnt + 19'h1 >= limit) begin
      st_d.level = raw_i;
      st_d.cnt   = '0;
    end else begin
      st_d.cnt = st_q.cnt + 19'h1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign level_o = st_q.level;

endmodule : trig_filter

/* trig_io_props.sv */
`timescale 1ns/1ps
module trig_io_props
  import trig_io_pkg::*;
(
  // clock and reset
  input wire logic                 sys_clk_i,
  input wire logic                 rst_b_i,
  // register port
  input wire logic [5:0]           reg_addr_i,
  input wire logic [31:0]          reg_wdata_i,
  input wire logic                 reg_wr_i,
  input wire logic                 reg_rd_i,
  input wire logic [31:0]          reg_rdata_o,
  // events, pins and outputs
  input wire logic [NUM_LINES-1:0] exposure_done_i,
  input wire logic [NUM_LINES-1:0] strobe_req_i,
  input wire logic [NUM_LINES-1:0] camera_present_i,
  input wire logic [NUM_LINES-1:0] trigger_pin_i,
  input wire logic [NUM_LINES-1:0] trigger_o,
  input wire logic [NUM_LINES-1:0] strobe_trigger_out_o
);
  logic        sel_q, nc_q, act5;
  logic [7:0]  pol_q, d0_q, pold_q;
  logic [2:0]  p_q;
  logic [13:0] st_q, run_q;
  // output register lags the polarity setting by one cycle
  assign act5 = strobe_trigger_out_o[5] ^ pold_q[5];
  // shadow of the mode bits, pin stability and pulse length counters
  always_ff @(posedge sys_clk_i) begin
    p_q   <= {p_q[1:0], trigger_pin_i[0]};
    pold_q <= pol_q;
    st_q  <= (!rst_b_i || p_q[2] != p_q[1]) ? 14'h0 : st_q + {13'h0, ~&st_q};
    run_q <= (!rst_b_i || !act5) ? 14'h0 : run_q + {13'h0, ~&run_q};
    if (!rst_b_i) begin
      sel_q <= 1'b0;
      nc_q  <= 1'b0;
      pol_q <= 8'h00;
      d0_q  <= 8'hff;
    end else if (reg_wr_i && reg_addr_i == 6'h00) begin
      sel_q <= reg_wdata_i[0];
      nc_q  <= reg_wdata_i[10];
    end else if (reg_wr_i && reg_addr_i[5:3] == 3'h2) begin
      pol_q[reg_addr_i[2:0]] <= reg_wdata_i[24];
      d0_q[reg_addr_i[2:0]]  <= (reg_wdata_i[6:0] == 7'h00);
    end
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  a_reset_quiet: assert property ($rose(rst_b_i) |-> strobe_trigger_out_o == 8'h00 && trigger_o == 8'h00)
    else $error("outputs not idle after reset");
  a_trig_wait: assert property ($changed(trigger_o[0]) |-> st_q >= 14'h2ee0)
    else $error("trigger changed before filter width");
  a_trig_level: assert property ($changed(trigger_o[0]) |-> trigger_o[0] == p_q[2])
    else $error("trigger level differs from pin");
  a_strobe_fire: assert property (!sel_q && nc_q && strobe_req_i[2] && !strobe_trigger_out_o[2]
    |-> ##[1:3] strobe_trigger_out_o[2])
    else $error("strobe without camera missing");
  a_strobe_block: assert property (!sel_q && !nc_q && !camera_present_i[2] && strobe_req_i[2]
    && !strobe_trigger_out_o[2] |=> !strobe_trigger_out_o[2] [*3])
    else $error("strobe issued without camera");
  a_mode_strobe: assert property (!sel_q && $past(sel_q, 3) == 1'b0 |-> (strobe_trigger_out_o & ~$past(strobe_trigger_out_o)
    & ~($past(strobe_req_i) | $past(strobe_req_i, 2) | $past(strobe_req_i, 3))) == 8'h00)
    else $error("strobe output rose without request");
  a_expo_fast: assert property (sel_q && $past(sel_q) && d0_q[5] && $stable(pol_q) && exposure_done_i[5] && !act5
    |-> ##[1:3] act5)
    else $error("zero delay pulse late");
  a_expo_width: assert property (sel_q && $past(sel_q) && $stable(pol_q) && $fell(act5) |-> run_q >= 14'h0e74)
    else $error("exposure pulse too short");
  c_trig: cover property ($changed(trigger_o[0]));
  c_expo: cover property (sel_q && $fell(act5));
  c_strobe: cover property (!sel_q && nc_q && strobe_req_i[2]);
endmodule : trig_io_props

/* ctrl_model.sv */
`timescale 1ns/1ps
module ctrl_model (
  // clock and watched pulses
  input  wire logic       sys_clk_i,
  input  wire logic [7:0] pulse_i,
  // events and pins
  output logic [7:0]      done_o,
  output logic [7:0]      req_o,
  output logic [7:0]      cam_o,
  output logic [7:0]      pin_o
);
  initial begin
    done_o = 8'h00;
    req_o  = 8'h00;
    cam_o  = 8'h00;
    pin_o  = 8'h00;
  end
  task expose(input int n, input logic idle);
    while (pulse_i[n] !== idle) @(posedge sys_clk_i);
    done_o[n] <= 1'b1;
    @(posedge sys_clk_i);
    done_o[n] <= 1'b0;
    @(posedge sys_clk_i);
  endtask : expose
  task strobe(input int n);
    req_o[n] <= 1'b1;
    @(posedge sys_clk_i);
    req_o[n] <= 1'b0;
    @(posedge sys_clk_i);
  endtask : strobe
  task pins(input logic [7:0] v);
    pin_o <= v;
  endtask : pins
endmodule : ctrl_model

/* tb.sv */
`timescale 1ns/1ps
module tb;
  import trig_io_pkg::*;
  logic        sys_clk_i, rst_b_i, reg_wr_i, reg_rd_i;
  logic [5:0]  reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o;
  logic [7:0]  exposure_done_i, strobe_req_i, camera_present_i, trigger_pin_i, trigger_o, strobe_trigger_out_o;
  int          error_cnt = 0, checks_done = 0, cyc = 0, n;
  trig_io_timing u_dut (.sys_clk_i, .rst_b_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .exposure_done_i, .strobe_req_i, .camera_present_i, .trigger_pin_i, .trigger_o, .strobe_trigger_out_o);
  ctrl_model u_ctrl (.sys_clk_i, .pulse_i(strobe_trigger_out_o), .done_o(exposure_done_i), .req_o(strobe_req_i),
    .cam_o(camera_present_i), .pin_o(trigger_pin_i));
  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 90000) begin
      error_cnt++;
      conclude();
    end
  end
  task conclude();
    if (error_cnt == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude
  task chk(input logic [31:0] s, input logic [31:0] e, input string nm);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task rng(input int lo, input int hi, input string nm);
    chk({31'h0, n >= lo && n <= hi}, 32'h1, nm);
  endtask : rng
  task wr(input logic [5:0] a, input logic [31:0] d);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask : wr
  task rd(input logic [5:0] a, input logic [31:0] e, input string nm);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1 chk(reg_rdata_o, e, nm);
    @(posedge sys_clk_i);
  endtask : rd
  task meas(input int b, input logic lvl);
    n = 0;
    #1;
    while (strobe_trigger_out_o[b] !== lvl && n < 20000) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
  endtask : meas
  initial begin
    rst_b_i     = 1'b0;
    reg_wr_i    = 1'b0;
    reg_rd_i    = 1'b0;
    reg_addr_i  = 6'h00;
    reg_wdata_i = 32'h0;
    repeat (5) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    @(posedge sys_clk_i);
    rd(6'h10, 32'h0001f400, "line cfg");
    rd(6'h00, 32'h0, "common");
    rd(6'h3f, 32'h0, "unmapped");
    wr(6'h11, 32'h0003ff7f);
    rd(6'h11, 32'h0003e864, "clamped cfg");
    for (int i = 0; i < 6; i++) begin
      wr(6'(6'h20 + i), 32'(i));
      rd(6'(6'h20 + i), 32'((i > 4) ? 4 : i), "filter code");
    end
    wr(6'h12, 32'h00000400);
    u_ctrl.strobe(2);
    repeat (10) @(posedge sys_clk_i);
    chk(32'(strobe_trigger_out_o), 32'h0, "no camera strobe");
    wr(6'h00, 32'h00000400);
    u_ctrl.strobe(2);
    meas(2, 1'b1);
    rng(0, 3, "strobe start");
    chk(32'(strobe_trigger_out_o), 32'h04, "strobe connector");
    meas(2, 1'b0);
    rng(3700, 5002, "strobe width");
    wr(6'h00, 32'h1);
    wr(6'h13, 32'h00000402);
    u_ctrl.expose(3, 1'b0);
    meas(3, 1'b1);
    rng(1240, 2503, "pulse delay");
    chk(32'(strobe_trigger_out_o), 32'h08, "line index");
    meas(3, 1'b0);
    rng(3740, 5002, "pulse width");
    wr(6'h15, 32'h01000400);
    repeat (3) @(posedge sys_clk_i);
    chk(32'(strobe_trigger_out_o), 32'h20, "negative idle");
    u_ctrl.expose(5, 1'b1);
    meas(5, 1'b0);
    rng(0, 3, "negative start");
    chk(32'(strobe_trigger_out_o), 32'h00, "other lines");
    meas(5, 1'b1);
    rng(3740, 5002, "negative width");
    wr(6'h00, 32'h3);
    wr(6'h20, 32'h1);
    u_ctrl.pins(8'h05);
    repeat (20000) @(posedge sys_clk_i);
    chk(32'(trigger_o), 32'h0, "filter hold on");
    repeat (5100) @(posedge sys_clk_i);
    chk(32'(trigger_o), 32'h05, "filter on");
    rd(6'h01, 32'h00050000, "status");
    u_ctrl.pins(8'h00);
    repeat (20000) @(posedge sys_clk_i);
    chk(32'(trigger_o), 32'h05, "filter hold off");
    repeat (5100) @(posedge sys_clk_i);
    chk(32'(trigger_o), 32'h0, "filter off");
    conclude();
  end
endmodule : tb
bind trig_io_timing trig_io_props u_props (.sys_clk_i, .rst_b_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
  .reg_rdata_o, .exposure_done_i, .strobe_req_i, .camera_present_i, .trigger_pin_i, .trigger_o, .strobe_trigger_out_o);
